// ===== design/uhgl_pkg.sv
package uhgl_pkg;
  // Core clock rate and line rates
  localparam int unsigned CLK_HZ        = 100_000_000;
  localparam int unsigned BAUD_HW       = 115_200;
  localparam int unsigned BAUD_SW       = 57_600;
  localparam int unsigned OVERSAMPLE    = 16;
  // Oversample tick divisors, rounded down
  localparam int unsigned DIV_HW        = CLK_HZ / (BAUD_HW * OVERSAMPLE);
  localparam int unsigned DIV_SW        = CLK_HZ / (BAUD_SW * OVERSAMPLE);
  localparam int unsigned DIV_W         = 16;
  // Character format: 8 data bits, no parity, 1 stop bit
  localparam int unsigned DATA_BITS     = 8;
  localparam int unsigned STOP_BITS     = 1;
  // Flow-control characters
  localparam logic [7:0]  XON_CHAR      = 8'h11;
  localparam logic [7:0]  XOFF_CHAR     = 8'h13;
  // Flow-control mode codes held in the nonvolatile settings
  localparam logic        MODE_HW       = 1'h0;
  localparam logic        MODE_SW       = 1'h1;
  // Controller register offsets
  localparam logic [3:0]  REG_CTRL      = 4'h0;
  localparam logic [3:0]  REG_STATUS    = 4'h1;
  localparam logic [3:0]  REG_IRQ_STAT  = 4'h2;
  localparam logic [3:0]  REG_IRQ_MASK  = 4'h3;
  localparam logic [3:0]  REG_TX_DATA   = 4'h4;
  localparam logic [3:0]  REG_RX_DATA   = 4'h5;
  // Control field positions
  localparam int unsigned CTRL_MODE     = 0;
  localparam int unsigned CTRL_RESET    = 1;
  localparam int unsigned CTRL_RX_STOP  = 2;
  // Interrupt bit positions
  localparam int unsigned IRQ_RX_DONE   = 0;
  localparam int unsigned IRQ_TX_DONE   = 1;
  localparam int unsigned IRQ_FRAME_ERR = 2;
  localparam int unsigned IRQ_W         = 3;
  // Reset values
  localparam logic [2:0]  CTRL_RESET_VAL = 3'h2;
  localparam logic [2:0]  MASK_RESET_VAL = 3'h0;
  // Transmitter and receiver state encodings
  typedef enum logic [3:0] {
    TX_IDLE  = 4'h1,
    TX_START = 4'h2,
    TX_DATA  = 4'h4,
    TX_STOP  = 4'h8
  } uhgl_tx_state_t;
  typedef enum logic [3:0] {
    RX_IDLE  = 4'h1,
    RX_START = 4'h2,
    RX_DATA  = 4'h4,
    RX_STOP  = 4'h8
  } uhgl_rx_state_t;
endpackage

// ===== design/uhgl_link_if.sv
`timescale 1ns/1ps
// Serial lines between device and host
interface uhgl_link_if;
  logic deviceTxd;
  logic hostTxd;
  logic hostTxPermitN;
  logic deviceTxPermitN;
  logic chipResetN;
  modport device (output deviceTxd, input hostTxd, output hostTxPermitN,
                  input deviceTxPermitN, input chipResetN);
  modport host   (input deviceTxd, output hostTxd, input hostTxPermitN,
                  output deviceTxPermitN, output chipResetN);
endinterface

// ===== design/uhgl_uart_core.sv
`timescale 1ns/1ps
// One full-duplex character engine shared by both ends
module uhgl_uart_core #(
  parameter int unsigned OVS = uhgl_pkg::OVERSAMPLE
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Configuration
  input  wire logic [15:0] divisor,
  input  wire logic        permitTx,
  // Transmit side
  input  wire logic        txValid,
  input  wire logic [7:0]  txData,
  output logic             txReady,
  output logic             txDone,
  output logic             serialOut,
  // Receive side
  input  wire logic        serialIn,
  output logic             rxValid,
  output logic [7:0]       rxData,
  output logic             frameErr
);
  import uhgl_pkg::*;

  if (OVS < 4 || OVS > 256) begin : g_ovs_check
    $error("OVS out of range");
  end

  logic [15:0]    tickCnt_reg;
  logic           tick;
  uhgl_tx_state_t txState_reg;
  logic [7:0]     txShift_reg;
  logic [7:0]     txOvs_reg;
  logic [2:0]     txBit_reg;
  uhgl_rx_state_t rxState_reg;
  logic [7:0]     rxShift_reg;
  logic [7:0]     rxOvs_reg;
  logic [2:0]     rxBit_reg;
  logic           rxMeta_reg;
  logic           rxSync_reg;
  logic           rxPrev_reg;
  localparam logic [7:0] OVS_LAST = 8'(OVS - 1);
  localparam logic [7:0] OVS_MID  = 8'(OVS / 2 - 1);

  // Oversample tick generator
  always_ff @(posedge core_clk) begin
    if (!resetn || tickCnt_reg >= divisor - 16'h0001) tickCnt_reg <= 16'h0000;
    else tickCnt_reg <= tickCnt_reg + 16'h0001;
  end
  assign tick = (tickCnt_reg >= divisor - 16'h0001);

  assign txReady = (txState_reg == TX_IDLE) && permitTx && tick; // [RQ6] full-length start bit

  // Transmitter: start low, 8 data LSB first, stop high
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      txState_reg <= TX_IDLE;
      serialOut   <= 1'b1;
      txShift_reg <= 8'h00;
      txOvs_reg   <= 8'h00;
      txBit_reg   <= 3'h0;
      txDone      <= 1'b0;
    end else begin
      txDone <= 1'b0;
      case (txState_reg)
        TX_IDLE: begin
          serialOut <= 1'b1; // [RQ1]
          if (txValid && txReady) begin
            txShift_reg <= txData;
            txOvs_reg   <= 8'h00;
            serialOut   <= 1'b0; // [RQ2]
            txState_reg <= TX_START;
          end
        end
        TX_START: if (tick) begin
          if (txOvs_reg == OVS_LAST) begin
            txOvs_reg   <= 8'h00;
            txBit_reg   <= 3'h0;
            serialOut   <= txShift_reg[0]; // [RQ3]
            txState_reg <= TX_DATA;
          end else txOvs_reg <= txOvs_reg + 8'h01;
        end
        TX_DATA: if (tick) begin
          if (txOvs_reg == OVS_LAST) begin
            txOvs_reg <= 8'h00;
            if (txBit_reg == 3'(DATA_BITS - 1)) begin // [RQ11]
              serialOut   <= 1'b1; // [RQ2]
              txState_reg <= TX_STOP;
            end else begin
              txBit_reg   <= txBit_reg + 3'h1;
              serialOut   <= txShift_reg[txBit_reg + 3'h1]; // [RQ3]
            end
          end else txOvs_reg <= txOvs_reg + 8'h01;
        end
        TX_STOP: if (tick) begin
          if (txOvs_reg == OVS_LAST) begin
            txDone      <= 1'b1;
            txState_reg <= TX_IDLE;
          end else txOvs_reg <= txOvs_reg + 8'h01;
        end
        default: txState_reg <= TX_IDLE;
      endcase
    end
  end

  // Two-stage synchroniser on the incoming line
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxMeta_reg <= 1'b1;
      rxSync_reg <= 1'b1;
      rxPrev_reg <= 1'b1;
    end else begin
      rxMeta_reg <= serialIn;
      rxSync_reg <= rxMeta_reg;
      rxPrev_reg <= rxSync_reg;
    end
  end

  // Receiver samples mid-bit; a low stop bit is a framing error
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxState_reg <= RX_IDLE;
      rxShift_reg <= 8'h00;
      rxOvs_reg   <= 8'h00;
      rxBit_reg   <= 3'h0;
      rxValid     <= 1'b0;
      rxData      <= 8'h00;
      frameErr    <= 1'b0;
    end else begin
      rxValid  <= 1'b0;
      frameErr <= 1'b0;
      case (rxState_reg)
        RX_IDLE: if (!rxSync_reg && rxPrev_reg) begin // Falling edge only: a low stop is no start
          rxOvs_reg   <= 8'h00;
          rxState_reg <= RX_START;
        end
        RX_START: if (tick) begin
          if (rxOvs_reg == OVS_MID) begin // [RQ16]
            rxOvs_reg <= 8'h00;
            rxBit_reg <= 3'h0;
            // Glitch shorter than half a bit is ignored
            rxState_reg <= rxSync_reg ? RX_IDLE : RX_DATA;
          end else rxOvs_reg <= rxOvs_reg + 8'h01;
        end
        RX_DATA: if (tick) begin
          if (rxOvs_reg == OVS_LAST) begin
            rxOvs_reg   <= 8'h00;
            rxShift_reg <= {rxSync_reg, rxShift_reg[7:1]}; // [RQ3]
            if (rxBit_reg == 3'(DATA_BITS - 1)) rxState_reg <= RX_STOP;
            else rxBit_reg <= rxBit_reg + 3'h1;
          end else rxOvs_reg <= rxOvs_reg + 8'h01;
        end
        RX_STOP: if (tick) begin
          if (rxOvs_reg == OVS_LAST) begin
            rxData      <= rxShift_reg;
            rxValid     <= rxSync_reg;
            frameErr    <= !rxSync_reg; // [RQ16]
            rxState_reg <= RX_IDLE;
          end else rxOvs_reg <= rxOvs_reg + 8'h01;
        end
        default: rxState_reg <= RX_IDLE;
      endcase
    end
  end
endmodule // uhgl_uart_core

// ===== design/uhgl_device_end.sv
`timescale 1ns/1ps
// What this block does
// RQ1: Idle serial output stays high.
// RQ2: Low start bit, high stop bit.
// RQ3: Data LSB first, non-inverted levels.
// RQ4: Handshake lines active low.
// RQ5: Host sends only while device permits.
// RQ6: Device sends only while host permits.
// RQ7: Unconnected permit input reads asserted.
// RQ8: XON/XOFF usable instead of hardware handshake.
// RQ9: Hardware handshake mode runs 115200 bps. This block takes its rate from nvDivisor in either mode.
// RQ10: XON/XOFF mode runs 57600 bps. This block takes its rate from nvDivisor in either mode.
// RQ11: Eight data bits, no parity, one stop.
// RQ12: Full duplex, both lines connected.
// RQ13: Host resets device through reset pin.
// RQ14: Rate and mode from nonvolatile settings.
// RQ15: Upper protocol detects errors and recovers.
// RQ16: Mid-bit sampling; low stop flags error.
module uhgl_device_end (
  // Clock and reset
  input  wire logic         core_clk,
  input  wire logic         resetn,
  // Link
  uhgl_link_if.device       link,
  // Nonvolatile settings
  input  wire logic         nvMode,
  input  wire logic [15:0]  nvDivisor,
  input  wire logic         permitFloating,
  // User transmit stream
  input  wire logic         txValid,
  input  wire logic [7:0]   txData,
  output logic              txReady,
  // User receive stream
  output logic              rxValid,
  output logic [7:0]        rxData,
  output logic              frameErr,
  input  wire logic         rxStall
);
  import uhgl_pkg::*;

  logic       modeSw_reg;
  logic [15:0] div_reg;
  logic       rstMeta_reg;
  logic       rstSync_reg;
  logic       permMeta_reg;
  logic       permSync_reg;
  logic       localRstN;
  logic       xoffSeen_reg;
  logic       sentXoff_reg;
  logic       flowPend_reg;
  logic       coreTxValid;
  logic [7:0] coreTxData;
  logic       coreTxReady;
  logic       permitTx;
  logic       coreRxValid;
  logic [7:0] coreRxData;
  logic       coreFrameErr;

  // Reset pin synchronised, combined with the core reset
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= link.chipResetN; // [RQ13]
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign localRstN = resetn && rstSync_reg;

  // Line rate and mode reloaded from the settings whenever they change, after release
  always_ff @(posedge core_clk) begin
    if (!localRstN) begin
      modeSw_reg <= MODE_HW;
      div_reg    <= 16'(DIV_HW);
    end else if (!rstSync_reg || modeSw_reg != nvMode || div_reg != nvDivisor) begin
      modeSw_reg <= nvMode; // [RQ14]
      div_reg    <= nvDivisor;
    end
  end

  // Permit input: a floating pin is pulled low, so treated as asserted
  always_ff @(posedge core_clk) begin
    if (!localRstN) begin
      permMeta_reg <= 1'b1;
      permSync_reg <= 1'b1;
    end else begin
      permMeta_reg <= permitFloating ? 1'b0 : link.deviceTxPermitN; // [RQ7]
      permSync_reg <= permMeta_reg;
    end
  end

  // Software flow: track XON/XOFF from host and our own receive stall
  always_ff @(posedge core_clk) begin
    if (!localRstN) begin
      xoffSeen_reg <= 1'b0;
      sentXoff_reg <= 1'b0;
      flowPend_reg <= 1'b0;
    end else begin
      if (modeSw_reg == MODE_SW && coreRxValid && coreRxData == XOFF_CHAR) xoffSeen_reg <= 1'b1;
      else if (modeSw_reg == MODE_SW && coreRxValid && coreRxData == XON_CHAR) xoffSeen_reg <= 1'b0;
      if (modeSw_reg == MODE_SW && rxStall != sentXoff_reg) flowPend_reg <= 1'b1; // [RQ8]
      if (flowPend_reg && coreTxReady) begin
        flowPend_reg <= 1'b0;
        sentXoff_reg <= rxStall;
      end
    end
  end

  // Hardware mode obeys the active-low permit; software mode the XOFF state
  assign permitTx = (modeSw_reg == MODE_HW) ? !permSync_reg : !xoffSeen_reg; // [RQ4] [RQ6]
  assign coreTxValid = flowPend_reg || txValid;
  assign coreTxData  = flowPend_reg ? (rxStall ? XOFF_CHAR : XON_CHAR) : txData;
  assign txReady     = coreTxReady && !flowPend_reg;

  // Request line low grants the host permission to send
  always_ff @(posedge core_clk) begin
    if (!localRstN) link.hostTxPermitN <= 1'b1;
    else link.hostTxPermitN <= (modeSw_reg == MODE_HW) ? rxStall : 1'b0; // [RQ4] [RQ5]
  end

  // Flow characters are consumed here in software mode
  assign rxValid = coreRxValid &&
                   !(modeSw_reg == MODE_SW && (coreRxData == XON_CHAR || coreRxData == XOFF_CHAR));
  assign rxData   = coreRxData;
  assign frameErr = coreFrameErr; // [RQ15]

  // Independent transmit and receive lines
  uhgl_uart_core #(.OVS(OVERSAMPLE)) uCore ( // [RQ12]
    .core_clk  (core_clk),
    .resetn    (localRstN),
    .divisor   (div_reg), // [RQ9] [RQ10]
    .permitTx  (permitTx),
    .txValid   (coreTxValid),
    .txData    (coreTxData),
    .txReady   (coreTxReady),
    .txDone    (),
    .serialOut (link.deviceTxd),
    .serialIn  (link.hostTxd),
    .rxValid   (coreRxValid),
    .rxData    (coreRxData),
    .frameErr  (coreFrameErr)
  );
endmodule // uhgl_device_end

// ===== design/uhgl_host_end.sv
`timescale 1ns/1ps
// Host serial port with register control, XON/XOFF and device reset
module uhgl_host_end (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Link
  uhgl_link_if.host        link,
  // Register port
  input  wire logic [3:0]  regAddr,
  input  wire logic [31:0] regWdata,
  input  wire logic        regWr,
  input  wire logic        regRd,
  output logic [31:0]      regRdata,
  // Interrupt
  output logic             irq
);
  import uhgl_pkg::*;

  logic [2:0]         ctrl_reg;
  logic [IRQ_W-1:0]   irqStat_reg;
  logic [IRQ_W-1:0]   irqMask_reg;
  logic [7:0]         rxHold_reg;
  logic               rxFull_reg;
  logic               txPend_reg;
  logic [7:0]         txHold_reg;
  logic               permMeta_reg;
  logic               permSync_reg;
  logic               xoffSeen_reg;
  logic               permitTx;
  logic               coreTxReady;
  logic               txDone;
  logic               coreRxValid;
  logic [7:0]         coreRxData;
  logic               coreFrameErr;
  logic [IRQ_W-1:0]   evt;
  logic               isFlow;

  // Control, interrupt mask and transmit holding register
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      ctrl_reg    <= CTRL_RESET_VAL;
      irqMask_reg <= MASK_RESET_VAL;
      txPend_reg  <= 1'b0;
      txHold_reg  <= 8'h00;
    end else begin
      if (regWr && regAddr == REG_CTRL) ctrl_reg <= regWdata[2:0];
      if (regWr && regAddr == REG_IRQ_MASK) irqMask_reg <= regWdata[IRQ_W-1:0];
      if (regWr && regAddr == REG_TX_DATA) begin
        txPend_reg <= 1'b1;
        txHold_reg <= regWdata[7:0];
      end else if (txPend_reg && coreTxReady) txPend_reg <= 1'b0;
    end
  end

  assign isFlow = ctrl_reg[CTRL_MODE] == MODE_SW &&
                  (coreRxData == XON_CHAR || coreRxData == XOFF_CHAR);
  assign evt = {coreFrameErr, txDone, coreRxValid && !isFlow};

  // Set wins over a write-one clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (!resetn) irqStat_reg <= '0;
    else irqStat_reg <= (irqStat_reg & ~((regWr && regAddr == REG_IRQ_STAT)
                         ? regWdata[IRQ_W-1:0] : '0)) | evt;
  end
  assign irq = |(irqStat_reg & irqMask_reg);

  // Receive holding register; reading it frees the slot
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      rxHold_reg <= 8'h00;
      rxFull_reg <= 1'b0;
    end else if (coreRxValid && !isFlow) begin
      rxHold_reg <= coreRxData;
      rxFull_reg <= 1'b1;
    end else if (regRd && regAddr == REG_RX_DATA) rxFull_reg <= 1'b0;
  end

  // Read data one cycle after the strobe
  always_ff @(posedge core_clk) begin
    if (!resetn) regRdata <= 32'h0000_0000;
    else if (!regRd) regRdata <= 32'h0000_0000;
    else if (regAddr == REG_CTRL) regRdata <= {29'h0, ctrl_reg};
    else if (regAddr == REG_STATUS) regRdata <= {28'h0, xoffSeen_reg, !permitTx, rxFull_reg, txPend_reg};
    else if (regAddr == REG_IRQ_STAT) regRdata <= {29'h0, irqStat_reg};
    else if (regAddr == REG_IRQ_MASK) regRdata <= {29'h0, irqMask_reg};
    else if (regAddr == REG_RX_DATA) regRdata <= {24'h0, rxHold_reg};
    else regRdata <= 32'h0000_0000;
  end

  // Device request line synchronised
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      permMeta_reg <= 1'b1;
      permSync_reg <= 1'b1;
    end else begin
      permMeta_reg <= link.hostTxPermitN;
      permSync_reg <= permMeta_reg;
    end
  end

  // XOFF from the device pauses us in software mode
  always_ff @(posedge core_clk) begin
    if (!resetn) xoffSeen_reg <= 1'b0;
    else if (coreRxValid && ctrl_reg[CTRL_MODE] == MODE_SW) begin
      if (coreRxData == XOFF_CHAR) xoffSeen_reg <= 1'b1; // [RQ8]
      else if (coreRxData == XON_CHAR) xoffSeen_reg <= 1'b0;
    end
  end

  assign permitTx = (ctrl_reg[CTRL_MODE] == MODE_HW) ? !permSync_reg : !xoffSeen_reg; // [RQ5]

  // Outgoing handshake and device reset pins, active low
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      link.deviceTxPermitN <= 1'b1;
      link.chipResetN      <= 1'b0;
    end else begin
      link.deviceTxPermitN <= ctrl_reg[CTRL_RX_STOP] || rxFull_reg; // [RQ4]
      link.chipResetN      <= !ctrl_reg[CTRL_RESET]; // [RQ13]
    end
  end

  uhgl_uart_core #(.OVS(OVERSAMPLE)) uCore ( // [RQ12]
    .core_clk  (core_clk),
    .resetn    (resetn),
    .divisor   (ctrl_reg[CTRL_MODE] == MODE_HW ? 16'(DIV_HW) : 16'(DIV_SW)), // [RQ9] [RQ10]
    .permitTx  (permitTx),
    .txValid   (txPend_reg),
    .txData    (txHold_reg),
    .txReady   (coreTxReady),
    .txDone    (txDone),
    .serialOut (link.hostTxd), // [RQ1] [RQ2] [RQ3] [RQ11]
    .serialIn  (link.deviceTxd),
    .rxValid   (coreRxValid),
    .rxData    (coreRxData),
    .frameErr  (coreFrameErr)
  );
endmodule // uhgl_host_end

// ===== tb/uhgl_link_checker.sv
`timescale 1ns/1ps
// Frame timing watcher for one serial line
module uhgl_frame_mon (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        resetn,
  // Watched line and its bit length in clocks
  input  wire logic        line,
  input  wire logic [15:0] bitClks,
  output logic             start,
  output logic [2:0]       bad
);
  logic        busy;
  logic        prevLine;
  logic [15:0] cnt;
  logic [15:0] stopMid;
  // Frame ends at mid stop, so a back-to-back start is still caught
  assign stopMid = 16'(bitClks * 9) + (bitClks >> 1);
  assign start   = !busy && prevLine && !line;
  // Clocks since the falling edge that opened the frame
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      busy     <= 1'b0;
      prevLine <= 1'b1;
      cnt      <= 16'h0000;
    end else begin
      prevLine <= line;
      if (start) begin
        busy <= 1'b1;
        cnt  <= 16'h0001;
      end else if (busy) begin
        cnt <= cnt + 16'h0001;
        busy <= (cnt != stopMid);
      end
    end
  end
  // Frame faults seen on the line
  assign bad[2] = busy && cnt == (bitClks >> 1) && line;
  assign bad[1] = busy && cnt == stopMid && !line;
  assign bad[0] = busy && cnt % bitClks != 16'h0000 && line != prevLine;
endmodule // uhgl_frame_mon

// Link rules between the two ends
module uhgl_link_checker (
  // Clock and reset
  input  wire logic core_clk,
  input  wire logic resetn,
  // Link
  input  wire logic deviceTxd,
  input  wire logic hostTxd,
  input  wire logic hostTxPermitN,
  input  wire logic deviceTxPermitN,
  input  wire logic chipResetN,
  // Device settings and stall
  input  wire logic nvMode,
  input  wire logic permitFloating,
  input  wire logic rxStall
);
  import uhgl_pkg::*;
  logic [15:0] bitClks;
  logic        devStart;
  logic        hostStart;
  logic [2:0]  devBad;
  logic [2:0]  hostBad;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  // Host mode is kept equal to nvMode by the bench, so one rate serves both lines
  assign bitClks = 16'(OVERSAMPLE * (nvMode ? DIV_SW : DIV_HW));
  uhgl_frame_mon dev_mon (.core_clk(core_clk), .resetn(resetn), .line(deviceTxd),
                          .bitClks(bitClks), .start(devStart), .bad(devBad));
  uhgl_frame_mon host_mon (.core_clk(core_clk), .resetn(resetn), .line(hostTxd),
                           .bitClks(bitClks), .start(hostStart), .bad(hostBad));
  a_reset_line :
    assert property (!chipResetN [*5] |-> deviceTxd) else $error("line not idle in reset");
  a_reset_permit :
    assert property (!chipResetN [*5] |-> hostTxPermitN) else $error("permit given in reset");
  a_dev_hold :
    assert property ((deviceTxPermitN && !permitFloating) [*6] |=> !devStart)
      else $error("device sent without permit");
  a_host_hold :
    assert property ((hostTxPermitN && !nvMode) [*6] |=> !hostStart)
      else $error("host sent without permit");
  a_stall_map :
    assert property ((chipResetN && !nvMode && $stable(rxStall)) [*6] |-> hostTxPermitN == rxStall)
      else $error("permit does not follow stall");
  a_start_low :
    assert property (!devBad[2] && !hostBad[2]) else $error("start bit not low");
  a_stop_high :
    assert property (!devBad[1] && !hostBad[1]) else $error("stop bit not high");
  a_bit_steady :
    assert property (!devBad[0] && !hostBad[0])
      else $error("line moved inside a bit");
endmodule // uhgl_link_checker

// ===== tb/testbench.sv
`timescale 1ns/1ps
// Two ends face each other; a second device end faces a bench line driver
module testbench;
  import uhgl_pkg::*;
  localparam int BIT_HW = OVERSAMPLE * DIV_HW;
  localparam int BIT_SW = OVERSAMPLE * DIV_SW;
  // Short bit on the second link keeps the fault test cheap
  localparam logic [15:0] DIV2 = 16'h0002;
  logic        core_clk;
  logic        resetn;
  logic        nvMode;
  logic [15:0] nvDivisor;
  logic        permitFloating;
  logic        txValid;
  logic [7:0]  txData;
  logic        txReady;
  logic        rxStall;
  logic        rxValid;
  logic [7:0]  rxData;
  logic        rxValid2;
  logic [7:0]  rxData2;
  logic        frameErr2;
  logic [3:0]  regAddr;
  logic [31:0] regWdata;
  logic        regWr;
  logic        regRd;
  logic [31:0] regRdata;
  logic        irq;
  logic        rdSeen;
  int          err_total;
  int          checked;
  int          cyc;
  logic [31:0] qRd[$];
  logic [7:0]  qRx[$];
  logic [8:0]  q2[$];
  logic [7:0]  b[8];
  uhgl_link_if link ();
  uhgl_link_if link2 ();
  uhgl_device_end uhgl_device_end_i (.core_clk(core_clk), .resetn(resetn), .link(link.device),
    .nvMode(nvMode), .nvDivisor(nvDivisor), .permitFloating(permitFloating), .txValid(txValid),
    .txData(txData), .txReady(txReady), .rxValid(rxValid), .rxData(rxData), .frameErr(),
    .rxStall(rxStall));
  uhgl_device_end uhgl_device_end_i2 (.core_clk(core_clk), .resetn(resetn), .link(link2.device),
    .nvMode(MODE_HW), .nvDivisor(DIV2), .permitFloating(permitFloating), .txValid(1'b0),
    .txData(txData), .txReady(), .rxValid(rxValid2), .rxData(rxData2), .frameErr(frameErr2),
    .rxStall(1'b0));
  uhgl_host_end uhgl_host_end_i (.core_clk(core_clk), .resetn(resetn), .link(link.host),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .irq(irq));
  uhgl_link_checker uhgl_link_checker_i (.core_clk(core_clk), .resetn(resetn),
    .deviceTxd(link.deviceTxd), .hostTxd(link.hostTxd), .hostTxPermitN(link.hostTxPermitN),
    .deviceTxPermitN(link.deviceTxPermitN), .chipResetN(link.chipResetN), .nvMode(nvMode),
    .permitFloating(permitFloating), .rxStall(rxStall));
  assign link2.deviceTxPermitN = 1'b0;
  assign link2.chipResetN = resetn;
  // Clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic waitc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask
  // Expected read data is noted when the read is issued
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    qRd.push_back(e);
    @(posedge core_clk);
    regRd <= 1'b0;
  endtask
  // Valid stays up until ready is seen at an edge
  task automatic dtx(input logic [7:0] d);
    int k;
    @(posedge core_clk);
    txValid <= 1'b1;
    txData <= d;
    @(posedge core_clk);
    for (k = 0; k < 30000 && txReady !== 1'b1; k++) @(posedge core_clk);
    txValid <= 1'b0;
  endtask
  // One character on the second link with a chosen stop level
  task automatic ser(input logic [7:0] d, input logic stopBit);
    logic [9:0] v;
    v = {stopBit, d, 1'b0};
    q2.push_back(stopBit ? {1'b0, d} : 9'h100);
    for (int i = 0; i < 10; i++) begin
      link2.hostTxd <= v[i];
      waitc(16 * DIV2);
    end
    link2.hostTxd <= 1'b1;
    waitc(64);
  endtask
  task automatic final_report;
    $display("checked %0d err_total %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  // Result watcher: each result takes the oldest note
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 95000) begin
      err_total++;
      final_report();
    end
    if (rdSeen === 1'b1) chk("regRdata", qRd.size() ? qRd.pop_front() : 'x, regRdata);
    rdSeen <= regRd;
    if (rxValid === 1'b1) chk("devRx", qRx.size() ? qRx.pop_front() : 'x, rxData);
    if (rxValid2 === 1'b1 || frameErr2 === 1'b1)
      chk("dev2Rx", q2.size() ? q2.pop_front() : 'x, {frameErr2, frameErr2 ? 8'h00 : rxData2});
  end
  initial begin
    {regWr, regRd, txValid, rxStall, nvMode, permitFloating, resetn, rdSeen} = '0;
    regAddr = '0;
    regWdata = '0;
    txData = '0;
    nvDivisor = 16'(DIV_HW);
    link2.hostTxd = 1'b1;
    err_total = 0;
    checked = 0;
    cyc = 0;
    void'($urandom(32'h0130A14B));
    // Flow-control codes are kept out of payload bytes
    foreach (b[i]) begin
      b[i] = 8'($urandom);
      if (b[i] == XON_CHAR || b[i] == XOFF_CHAR) b[i] ^= 8'h80;
    end
    repeat (8) @(posedge core_clk);
    resetn <= 1'b1;
    rd(REG_CTRL, 32'(CTRL_RESET_VAL));
    rd(REG_IRQ_MASK, 32'(MASK_RESET_VAL));
    rd(4'hF, 32'h00000000);
    // Release the device, then both directions at once
    wr(REG_IRQ_MASK, 32'h00000007);
    wr(REG_CTRL, 32'h00000000);
    waitc(8);
    fork dtx(b[1]); join_none
    wr(REG_TX_DATA, 32'(b[2]));
    qRx.push_back(b[2]);
    waitc(10 * BIT_HW + 400);
    rd(REG_IRQ_STAT, 32'h00000003);
    chk("irq", 32'h1, 32'(irq));
    rd(REG_RX_DATA, 32'(b[1]));
    wr(REG_IRQ_STAT, 32'h00000003);
    waitc(1);
    chk("irq clear", 32'h0, 32'(irq));
    // Host withholds permit; an unconnected permit pin overrides it
    wr(REG_IRQ_MASK, 32'h00000002);
    wr(REG_CTRL, 32'h00000004);
    waitc(8);
    fork dtx(b[3]); join_none
    waitc(1500);
    chk("held line", 32'h1, 32'(link.deviceTxd));
    permitFloating <= 1'b1;
    waitc(10 * BIT_HW + 400);
    chk("masked irq", 32'h0, 32'(irq));
    rd(REG_IRQ_STAT, 32'h00000001);
    rd(REG_RX_DATA, 32'(b[3]));
    wr(REG_IRQ_MASK, 32'h00000001);
    waitc(1);
    chk("unmasked irq", 32'h1, 32'(irq));
    wr(REG_IRQ_STAT, 32'h00000001);
    permitFloating <= 1'b0;
    wr(REG_CTRL, 32'h00000000);
    // Receiver stall throttles the host
    rxStall <= 1'b1;
    waitc(8);
    wr(REG_TX_DATA, 32'(b[4]));
    qRx.push_back(b[4]);
    waitc(2000);
    chk("stalled", 32'h1, 32'(qRx.size()));
    rxStall <= 1'b0;
    waitc(10 * BIT_HW + 400);
    chk("stall over", 32'h0, 32'(qRx.size()));
    rd(REG_IRQ_STAT, 32'h00000002);
    chk("masked irq", 32'h0, 32'(irq));
    wr(REG_IRQ_STAT, 32'h00000007);
    // In-band flow control at the lower rate
    nvMode <= MODE_SW;
    nvDivisor <= 16'(DIV_SW);
    wr(REG_CTRL, 32'(MODE_SW));
    waitc(8);
    rxStall <= 1'b1;
    waitc(10 * BIT_SW + 400);
    rd(REG_STATUS, 32'h0000000C);
    wr(REG_TX_DATA, 32'(b[5]));
    qRx.push_back(b[5]);
    waitc(2000);
    rd(REG_STATUS, 32'h0000000D);
    rxStall <= 1'b0;
    waitc(20 * BIT_SW + 800);
    chk("resumed", 32'h0, 32'(qRx.size()));
    rd(REG_IRQ_STAT, 32'h00000002);
    // Low stop bit on the second link, then a clean character
    ser(b[6], 1'b0);
    ser(b[7], 1'b1);
    chk("dev2 left", 32'h0, 32'(q2.size()));
    final_report();
  end
endmodule // testbench
